// ===== logic/axr_map.svh
// Constants for the auxiliary converter readout: divider, widths, readback addresses
`ifndef AXR_MAP_SVH
`define AXR_MAP_SVH
`define AXR_NUM_CHANNELS    6
`define AXR_RESULT_BITS     10
`define AXR_SAMPLE_DIVIDE   6144
`define AXR_READBACK_BASE   16'hF5A0
`define AXR_READBACK_LAST   16'hF5A5
`define AXR_READ_WIDTH      16
`define AXR_CODE_ZERO       10'h000
`define AXR_CODE_FULL       10'h3FF
`endif

// ===== logic/axr_pkg.sv
// Types shared by the auxiliary converter readout
package axr_pkg;
  typedef logic [9:0]  axr_code_t;
  typedef logic [15:0] axr_addr_t;
  typedef logic [15:0] axr_word_t;
  typedef enum logic [1:0] {
    AXR_IDLE,
    AXR_CAPTURE,
    AXR_PUSH
  } axr_state_t;
endpackage : axr_pkg

// ===== logic/axr_readout.sv
// Auxiliary converter readout: sample strobe, readback registers, DSP stream
//
// Notes on behaviour
// (R1) Six independent channels each deliver a 10-bit result for their own input.
// (R2) Every channel is sampled once per 6144 system clock cycles.
// (R3) The sample rate is a fixed division of mclk, so it tracks the system clock.
// (R4) Results are unsigned, zero for ground and all ones for the analog supply.
// (R5) Each channel's latest result sits in its own readback register for the host.
// (R6) Input n goes to auxiliary slot n of the DSP program.
// (R7) Readback registers lie at 0xF5A0 plus channel, up to 0xF5A5.
// (R8) Readback changes only on the sample strobe, right-justified, upper bits zero.
`timescale 1ns/100ps
`include "axr_map.svh"

module axr_readout #(
  parameter int DIVIDE = `AXR_SAMPLE_DIVIDE,
  parameter int NCH    = `AXR_NUM_CHANNELS
) (
  input  wire logic                        mclk,
  input  wire logic                        rstn,
  input  wire logic [NCH*10-1:0]           conv_result,
  input  wire axr_pkg::axr_addr_t          host_addr,
  input  wire logic                        host_rd,
  output      axr_pkg::axr_word_t          host_rdata,
  output      logic                        host_rvalid,
  output      logic                        host_hit,
  output      logic                        sample_strobe,
  output      logic                        dsp_valid,
  input  wire logic                        dsp_ready,
  output      logic [2:0]                  dsp_slot,
  output      axr_pkg::axr_code_t          dsp_data
);
  import axr_pkg::*;

  // 13 bits covers the default ratio; a DIVIDE above 8192 needs a wider counter
  logic [12:0]      div_cnt;
  axr_code_t        aux_channel_readback [NCH];
  axr_state_t       state;
  logic [2:0]       push_ch;
  // Two-entry buffer toward the DSP
  logic [12:0]      buf_mem [2];
  logic             wr_ptr;
  logic             rd_ptr;
  logic [1:0]       buf_cnt;
  logic             buf_push;
  logic             buf_pop;
  logic             out_full;
  logic [15:0]      rel_addr;
  logic [2:0]       exp_slot;

  // Free divider from mclk, so the rate scales with the clock
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      div_cnt       <= 13'h0000;
      sample_strobe <= 1'b0;
    end else if (div_cnt == 13'(DIVIDE - 1)) begin
      div_cnt       <= 13'h0000;
      sample_strobe <= 1'b1; // see (R2) see (R3)
    end else begin
      div_cnt       <= div_cnt + 13'h0001;
      sample_strobe <= 1'b0;
    end
  end

  // Capture all channels at once; a host read never sees half an update
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      always_ff @(posedge mclk) begin
        if (!rstn) begin
          aux_channel_readback[g] <= `AXR_CODE_ZERO;
        end else if (div_cnt == 13'(DIVIDE - 1)) begin
          aux_channel_readback[g] <= conv_result[g*10 +: 10]; // see (R1) see (R4) see (R8)
        end
      end
      chk_readback_hold: assert property (@(posedge mclk) disable iff (!rstn) // see (R8)
        $past(div_cnt) != 13'(DIVIDE - 1) |-> $stable(aux_channel_readback[g]))
        else $error("readback changed without strobe");
      chk_readback_cap: assert property (@(posedge mclk) disable iff (!rstn) // see (R1)
        (div_cnt == 13'(DIVIDE - 1))
        |=> aux_channel_readback[g] == $past(conv_result[g*10 +: 10]))
        else $error("channel capture wrong");
    end
  endgenerate

  // Host readback decode; the range test keeps a wrapped offset from aliasing
  // Data and hit hold between reads, so a slow host may sample late
  assign rel_addr = host_addr - `AXR_READBACK_BASE;
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      host_rdata  <= 16'h0000;
      host_rvalid <= 1'b0;
      host_hit    <= 1'b0;
    end else begin
      host_rvalid <= host_rd;
      if (host_rd && host_addr >= `AXR_READBACK_BASE && host_addr <= `AXR_READBACK_LAST
          && rel_addr < 16'(NCH)) begin
        host_rdata <= {6'h00, aux_channel_readback[rel_addr[2:0]]}; // see (R5) see (R7)
        host_hit   <= 1'b1;
      end else if (host_rd) begin
        host_rdata <= 16'h0000; // Unmapped reads return zero
        host_hit   <= 1'b0;
      end
    end
  end

  // Walk the channels into the buffer after each strobe
  // A strobe landing while a walk is stalled is skipped, and the
  // rest of that walk then carries the newer capture
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      state   <= AXR_IDLE;
      push_ch <= 3'h0;
    end else begin
      case (state)
        AXR_IDLE: begin
          if (sample_strobe) begin
            state   <= AXR_PUSH;
            push_ch <= 3'h0;
          end
        end
        AXR_PUSH: begin
          if (buf_push) begin
            if (push_ch == 3'(NCH - 1)) begin
              state <= AXR_IDLE;
            end else begin
              push_ch <= push_ch + 3'h1; // see (R6)
            end
          end
        end
        default: state <= AXR_IDLE;
      endcase
    end
  end

  // Stall on a full buffer so no word is lost
  // Slot and code travel as one entry so they can never part
  assign buf_push = (state == AXR_PUSH) && (buf_cnt != 2'h2);
  assign buf_pop  = (buf_cnt != 2'h0) && (!out_full || (dsp_valid && dsp_ready));

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      wr_ptr  <= 1'b0;
      rd_ptr  <= 1'b0;
      buf_cnt <= 2'h0;
    end else begin
      if (buf_push) begin
        buf_mem[wr_ptr] <= {push_ch, aux_channel_readback[push_ch]}; // see (R6)
        wr_ptr          <= ~wr_ptr;
      end
      if (buf_pop) begin
        rd_ptr <= ~rd_ptr;
      end
      buf_cnt <= buf_cnt + {1'b0, buf_push} - {1'b0, buf_pop};
    end
  end

  // Registered output stage toward the DSP
  assign out_full = dsp_valid;
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      dsp_valid <= 1'b0;
      dsp_slot  <= 3'h0;
      dsp_data  <= `AXR_CODE_ZERO;
    end else if (buf_pop) begin
      dsp_valid <= 1'b1;
      dsp_slot  <= buf_mem[rd_ptr][12:10];
      dsp_data  <= buf_mem[rd_ptr][9:0];
    end else if (dsp_ready) begin
      dsp_valid <= 1'b0;
    end
  end

  // Slot expected next on the stream; feeds the order check only
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      exp_slot <= 3'h0;
    end else if (dsp_valid && dsp_ready) begin
      exp_slot <= (dsp_slot == 3'(NCH - 1)) ? 3'h0 : dsp_slot + 3'h1;
    end
  end

  // Checks
  chk_strobe_period: assert property (@(posedge mclk) disable iff (!rstn) // see (R2)
    sample_strobe |=> !sample_strobe [*8])
    else $error("sample strobe repeated too soon");
  chk_strobe_source: assert property (@(posedge mclk) disable iff (!rstn) // see (R2)
    sample_strobe |-> $past(div_cnt) == 13'(DIVIDE - 1))
    else $error("strobe without divider wrap");
  chk_div_range: assert property (@(posedge mclk) disable iff (!rstn) // see (R3)
    div_cnt < 13'(DIVIDE))
    else $error("divider count out of range");
  chk_read_upper: assert property (@(posedge mclk) disable iff (!rstn) // see (R4)
    host_rvalid |-> host_rdata[15:10] == 6'h00)
    else $error("upper readback bits not zero");
  chk_read_map: assert property (@(posedge mclk) disable iff (!rstn) // see (R7)
    host_rd && host_addr == 16'hF5A5 |=> host_hit)
    else $error("last readback address missed");
  chk_read_data: assert property (@(posedge mclk) disable iff (!rstn) // see (R5)
    host_rd && host_addr == 16'hF5A2 && div_cnt != 13'(DIVIDE - 1)
    |=> host_rdata[9:0] == aux_channel_readback[2])
    else $error("readback data mismatch");
  chk_dsp_hold: assert property (@(posedge mclk) disable iff (!rstn) // see (R6)
    dsp_valid && !dsp_ready |=> dsp_valid && $stable(dsp_slot) && $stable(dsp_data))
    else $error("dsp word dropped under stall");
  chk_rate_follow: assert property (@(posedge mclk) disable iff (!rstn) // see (R3)
    sample_strobe |-> div_cnt == 13'h0000)
    else $error("strobe not aligned to divider");
  chk_read_miss: assert property (@(posedge mclk) disable iff (!rstn) // see (R7)
    host_rd && (host_addr < `AXR_READBACK_BASE || host_addr > `AXR_READBACK_LAST)
    |=> !host_hit && host_rdata == 16'h0000)
    else $error("unmapped read returned data");
  // Stream order and buffer bounds
  chk_slot_range: assert property (@(posedge mclk) disable iff (!rstn) // see (R6)
    dsp_valid |-> dsp_slot < 3'(NCH))
    else $error("dsp slot beyond last channel");
  chk_slot_order: assert property (@(posedge mclk) disable iff (!rstn) // see (R6)
    dsp_valid |-> dsp_slot == exp_slot)
    else $error("dsp slot out of order");
  chk_buf_bound: assert property (@(posedge mclk) disable iff (!rstn) // see (R6)
    buf_cnt != 2'h3)
    else $error("stream buffer overflow");
endmodule : axr_readout

// ===== verification/axr_dsp_sink.sv
// DSP program side model that accepts auxiliary words
`timescale 1ns/100ps
module axr_dsp_sink (
  input  wire logic mclk,
  input  wire logic slow,
  output      logic dsp_ready = 1'b0
);
  logic [1:0] ph = 2'h0;
  // Slow mode takes one word in four so the buffer fills
  always @(posedge mclk) begin
    ph <= ph + 2'h1;
    dsp_ready <= slow ? (ph == 2'h3) : 1'b1;
  end
endmodule : axr_dsp_sink

// ===== verification/axr_readout_test.sv
// Self-checking bench for the auxiliary converter readout
`timescale 1ns/100ps
module axr_readout_test;
  import axr_pkg::*;
  localparam int DIV = 32;
  localparam axr_code_t C [6] = '{10'h000, 10'h001, 10'h2AA, 10'h155, 10'h1C3, 10'h3FF};
  logic        mclk = 1'b0;
  logic        rstn = 1'b0;
  logic [59:0] conv_result = '0;
  axr_addr_t   host_addr = '0;
  logic        host_rd = 1'b0;
  logic        slow = 1'b0;
  axr_word_t   host_rdata;
  logic        host_rvalid, host_hit, sample_strobe, dsp_valid, dsp_ready;
  logic [2:0]  dsp_slot;
  axr_code_t   dsp_data;
  int          err_total = 0;
  int          tests_run = 0;
  logic [12:0] got [$];
  always #5 mclk = ~mclk;
  axr_readout #(.DIVIDE(DIV)) DUT (.mclk(mclk), .rstn(rstn), .conv_result(conv_result),
    .host_addr(host_addr), .host_rd(host_rd), .host_rdata(host_rdata),
    .host_rvalid(host_rvalid), .host_hit(host_hit), .sample_strobe(sample_strobe),
    .dsp_valid(dsp_valid), .dsp_ready(dsp_ready), .dsp_slot(dsp_slot), .dsp_data(dsp_data));
  axr_dsp_sink sink (.mclk(mclk), .slow(slow), .dsp_ready(dsp_ready));
  // Log every word the DSP side accepts
  always @(posedge mclk) begin
    if (dsp_valid === 1'b1 && dsp_ready === 1'b1) got.push_back({dsp_slot, dsp_data});
  end
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    tests_run++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic put(input logic inv);
    for (int i = 0; i < 6; i++) conv_result[10*i+:10] <= inv ? ~C[i] : C[i];
  endtask : put
  // Wait for the strobe; a strobe that never comes counts as a mismatch
  task automatic wstrobe;
    logic seen;
    seen = 1'b0;
    for (int n = 0; n < 2 * DIV && !seen; n++) begin
      @(posedge mclk);
      seen = (sample_strobe === 1'b1);
    end
    chk("strobe_seen", {15'h0, seen}, 16'h0001);
  endtask : wstrobe
  // One host read, result judged in the cycle rvalid stands
  task automatic rd(input axr_addr_t a, input axr_word_t e, input logic h);
    @(posedge mclk);
    host_rd <= 1'b1;
    host_addr <= a;
    @(posedge mclk);
    host_rd <= 1'b0;
    #1;
    chk("rvalid_hit", {14'h0, host_rvalid, host_hit}, {14'h0, 1'b1, h});
    chk("rdata", host_rdata, e);
  endtask : rd
  // Outputs and readbacks come out of reset at zero
  task automatic t_reset;
    #1;
    chk("rvalid_hit", {14'h0, host_rvalid, host_hit}, 16'h0000);
    chk("rdata", host_rdata, 16'h0000);
    chk("strobe", {15'h0, sample_strobe}, 16'h0000);
    chk("dsp_out", {2'h0, dsp_valid, dsp_slot, dsp_data}, 16'h0000);
    for (int i = 0; i < 6; i++) rd(16'hF5A0 + 16'(i), 16'h0000, 1'b1);
    $display("reset test done");
  endtask : t_reset
  task automatic t_period;
    int n;
    wstrobe();
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (sample_strobe !== 1'b1 && n < 2 * DIV);
    chk("period", 16'(n), 16'(DIV));
    $display("period test done");
  endtask : t_period
  // Input changed after capture must not show until the next strobe
  task automatic t_readback;
    put(1'b0);
    wstrobe();
    wstrobe();
    put(1'b1);
    for (int i = 0; i < 6; i++) rd(16'hF5A0 + 16'(i), {6'h00, C[i]}, 1'b1);
    rd(16'hF5A6, 16'h0000, 1'b0);
    rd(16'hF59F, 16'h0000, 1'b0);
    wstrobe();
    rd(16'hF5A0, {6'h00, ~C[0]}, 1'b1);
    $display("readback test done");
  endtask : t_readback
  // Reset in the middle of a walk clears the stream and the readbacks
  task automatic t_midreset;
    put(1'b0);
    wstrobe();
    repeat (3) @(posedge mclk);
    rstn <= 1'b0;
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    #1;
    chk("dsp_valid", {15'h0, dsp_valid}, 16'h0000);
    chk("strobe", {15'h0, sample_strobe}, 16'h0000);
    rd(16'hF5A5, 16'h0000, 1'b1);
    $display("mid-run reset test done");
  endtask : t_midreset
  // Slow sink stalls the stream; no word may be lost or reordered
  task automatic t_stream(input logic s);
    slow <= s;
    put(1'b0);
    wstrobe();
    wstrobe();
    #1;
    got.delete();
    repeat (DIV - 2) @(posedge mclk);
    #1;
    chk("words", 16'(got.size()), 16'h0006);
    for (int i = 0; i < 6; i++) chk("word", 16'(got[i]), {3'h0, 3'(i), C[i]});
    $display("stream test done");
  endtask : t_stream
  task automatic results;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : results
  // Watchdog against a hung run
  initial begin
    #50000;
    err_total++;
    results();
  end
  // Main sequence
  initial begin
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    t_reset();
    t_period();
    t_readback();
    t_midreset();
    t_stream(1'b0);
    t_stream(1'b1);
    results();
  end
endmodule : axr_readout_test
